/* File: include/algc_defines.vh */
// Purpose: constants for the audio level gain control block
// Assumes: AXI4-Lite register access, 125 MHz clock
// Notes: gains are Q format, unity = 1 << GAIN_FRAC
// Operation
// R1 - read 5-bit dialogue level per frame
// R2 - scale each program to uniform dialogue level
// R3 - apply one range gain word per block
// R4 - range gain spans plus or minus 24 dB
// R5 - dialogue level is the unaffected reference
// R6 - after reset apply range words unmodified
// R7 - listener scale zero disables range gain
// R8 - separate scales for cut and boost
// R9 - dialogue level per stream before mixing
// R10 - range gain applies to its own stream
// R11 - three service types steer main level
// R12 - main level uses both streams' range words
// R13 - rewriters leave coded audio unchanged
// R14 - six audio blocks per sync frame
// R15 - service type codes 010, 101, 111
// R16 - standard encodings, gain changes at block edges
// R17 - multiply by combined gain and saturate
`ifndef ALGC_DEFINES_VH
`define ALGC_DEFINES_VH
`define ALGC_REG_CTRL 4'h0
`define ALGC_REG_SCALE 4'h4
`define ALGC_REG_STATUS 4'h8
`define ALGC_REG_GAIN 4'hC
`define ALGC_SCALE_RST 16'hFFFF
`define ALGC_BLOCKS_PER_FRAME 3'h6
`define ALGC_SVC_NARR 3'h2
`define ALGC_SVC_COMM 3'h5
`define ALGC_SVC_VOICE 3'h7
`define ALGC_GAIN_FRAC 14
`define ALGC_UNITY 18'h04000
`define ALGC_FIFO_DEPTH 32
`define ALGC_FIFO_AW 5
`endif

/* File: hdl/algc_fifo.v */
// Purpose: synchronous valid/ready FIFO
// Assumes: single clock
// Notes: width and depth shape the storage
`timescale 1ns/1ps
`default_nettype none
module algc_fifo #(
  parameter W = 18,
  parameter D = 32,
  parameter AW = 5
) (
  input wire clk_i, // clock
  input wire reset_i, // async reset
  input wire [W-1:0] in_data_i, // fill data
  input wire in_valid_i, // fill valid
  output wire in_ready_o, // not full
  output wire [W-1:0] out_data_o, // drain data
  output wire out_valid_o, // not empty
  input wire out_ready_i // drain ready
);
  reg [W-1:0] mem_r [0:D-1];
  reg [AW-1:0] wp_r;
  reg [AW-1:0] rp_r;
  reg [AW:0] cnt_r;
  reg rdy_r; // registered not-full, so the ready pin comes from a flop
  wire wr = in_valid_i && rdy_r;
  wire rd = out_valid_o && out_ready_i;
  wire [AW:0] cnt_nxt = cnt_r + {{AW{1'b0}}, wr} - {{AW{1'b0}}, rd};
  assign in_ready_o = rdy_r;
  assign out_valid_o = (cnt_r != 0);
  assign out_data_o = mem_r[rp_r];
  always @(posedge clk_i) begin
    if (wr) begin
      mem_r[wp_r] <= in_data_i;
    end
  end
  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      wp_r <= {AW{1'b0}};
      rp_r <= {AW{1'b0}};
      cnt_r <= {(AW+1){1'b0}};
      rdy_r <= 1'b1;
    end else begin
      if (wr) wp_r <= wp_r + 1'b1;
      if (rd) rp_r <= rp_r + 1'b1;
      cnt_r <= cnt_nxt;
      rdy_r <= (cnt_nxt != D);
    end
  end
endmodule
`default_nettype wire

/* File: hdl/algc_top.v */
// Purpose: dialogue normalization and range gain for main and associated
// Assumes: parser delivers fields synchronously; gains are linear Q4.14
// Notes: dB to linear conversion is done by the parser per coding standard
//
// The AXI4-Lite register port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "algc_defines.vh"
module algc_top (
  input wire clk_i, // 125 MHz clock
  input wire reset_i, // async reset, high
  // stream fields from parser
  input wire hdr_valid_i, // frame header pulse
  input wire hdr_assoc_i, // header belongs to associated stream
  input wire [4:0] dial_level_i, // 5-bit dialogue level field
  input wire [17:0] dial_gain_i, // linear gain for that level
  input wire [2:0] svc_type_i, // service type field
  input wire blk_valid_i, // range gain word pulse
  input wire blk_assoc_i, // word belongs to associated stream
  input wire [17:0] rng_gain_i, // linear range gain, unity=0x4000
  // samples
  input wire smp_valid_i, // sample valid
  output wire smp_ready_o, // sample ready (fifo not full)
  input wire smp_assoc_i, // sample from associated stream
  input wire smp_last_i, // last sample of block
  input wire [15:0] smp_i, // decoded sample
  output reg mix_valid_o, // scaled sample valid
  input wire mix_ready_i, // downstream ready
  output reg mix_assoc_o, // scaled sample stream id
  output reg [15:0] mix_o, // scaled sample, saturated
  // axi4-lite
  input wire [3:0] s_axi_awaddr, // write address
  input wire s_axi_awvalid, // write address valid
  output reg s_axi_awready, // write address ready
  input wire [31:0] s_axi_wdata, // write data
  input wire [3:0] s_axi_wstrb, // write strobes
  input wire s_axi_wvalid, // write data valid
  output reg s_axi_wready, // write data ready
  output reg [1:0] s_axi_bresp, // write response
  output reg s_axi_bvalid, // write response valid
  input wire s_axi_bready, // write response ready
  input wire [3:0] s_axi_araddr, // read address
  input wire s_axi_arvalid, // read address valid
  output reg s_axi_arready, // read address ready
  output reg [31:0] s_axi_rdata, // read data
  output reg [1:0] s_axi_rresp, // read response
  output reg s_axi_rvalid, // read data valid
  input wire s_axi_rready // read data ready
);
  // q4.14 multiply with positive-gain rounding down
  function [17:0] gmul;
    input [17:0] a;
    input [17:0] b;
    reg [35:0] p;
    begin
      p = a * b;
      gmul = (p[35:32] != 4'h0) ? 18'h3FFFF : p[31:14];
    end
  endfunction
  // scale a range gain toward unity by an 8-bit factor, 0xFF is full
  function [17:0] rscale;
    input [17:0] g;
    input [7:0] s;
    reg [26:0] d;
    begin
      if (g >= `ALGC_UNITY) begin
        d = (g - `ALGC_UNITY) * s;
        rscale = `ALGC_UNITY + ((s == 8'hFF) ? (g - `ALGC_UNITY) : d[25:8]);
      end else begin
        d = (`ALGC_UNITY - g) * s;
        rscale = `ALGC_UNITY - ((s == 8'hFF) ? (`ALGC_UNITY - g) : d[25:8]);
      end
    end
  endfunction
  function is_exc;
    input [2:0] t;
    begin
      is_exc = (t == `ALGC_SVC_NARR) || (t == `ALGC_SVC_COMM) ||
        (t == `ALGC_SVC_VOICE); // R11 R15
    end
  endfunction

  reg ctrl_en_r; // range gain applied
  reg [15:0] scale_r; // [7:0] cut scale, [15:8] boost scale
  reg [4:0] dl_m_r, dl_a_r; // R1
  reg [17:0] dg_m_r, dg_a_r;
  reg [2:0] svc_a_r;
  reg [17:0] rp_m_r, rp_a_r; // pending range words
  reg [17:0] rg_m_r, rg_a_r; // active range gains
  reg [2:0] blk_cnt_r;
  reg frame_err_r;
  reg [17:0] last_gain_r;

  wire [17:0] f_data;
  wire f_valid;
  wire f_ready;
  algc_fifo #(.W(18), .D(`ALGC_FIFO_DEPTH), .AW(`ALGC_FIFO_AW)) u_fifo (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .in_data_i({smp_last_i, smp_assoc_i, smp_i}),
    .in_valid_i(smp_valid_i),
    .in_ready_o(smp_ready_o),
    .out_data_o(f_data),
    .out_valid_o(f_valid),
    .out_ready_i(f_ready)
  );

  // scaled range gains for cut (below unity) and boost (above unity)
  // enable and scales are arguments so callers see their changes
  function [17:0] lscale;
    input [17:0] g;
    input en;
    input [15:0] sc;
    begin
      if (!en)
        lscale = `ALGC_UNITY; // R7
      else if (g < `ALGC_UNITY)
        lscale = rscale(g, sc[7:0]); // R8 R5
      else
        lscale = rscale(g, sc[15:8]); // R8 R5
    end
  endfunction

  wire samp_assoc = f_data[16];
  wire samp_last = f_data[17];
  wire exc = is_exc(svc_a_r);
  wire [17:0] rng_m_l = lscale(rg_m_r, ctrl_en_r, scale_r);
  wire [17:0] rng_a_l = lscale(rg_a_r, ctrl_en_r, scale_r);
  wire [17:0] rng_main = exc ? gmul(rng_m_l, rng_a_l) : rng_m_l; // R12 R10
  wire [17:0] rng_sel = samp_assoc ? rng_a_l : rng_main; // R10
  wire [17:0] dg_sel = samp_assoc ? dg_a_r : dg_m_r; // R9 R2
  wire [17:0] tot_gain = gmul(dg_sel, rng_sel); // R17
  wire signed [34:0] prod = $signed(f_data[15:0]) * $signed({1'b0, tot_gain});
  wire signed [20:0] shf = prod[34:14];
  wire [15:0] sat = (shf > 21'sd32767) ? 16'h7FFF :
    (shf < -21'sd32768) ? 16'h8000 : shf[15:0]; // R17

  assign f_ready = !mix_valid_o || mix_ready_i;

  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      dl_m_r <= 5'h00;
      dl_a_r <= 5'h00;
      dg_m_r <= `ALGC_UNITY;
      dg_a_r <= `ALGC_UNITY;
      svc_a_r <= 3'h0;
      rp_m_r <= `ALGC_UNITY;
      rp_a_r <= `ALGC_UNITY;
      rg_m_r <= `ALGC_UNITY;
      rg_a_r <= `ALGC_UNITY;
      blk_cnt_r <= 3'h0;
      frame_err_r <= 1'b0;
      mix_valid_o <= 1'b0;
      mix_assoc_o <= 1'b0;
      mix_o <= 16'h0000;
      last_gain_r <= `ALGC_UNITY;
    end else begin
      if (hdr_valid_i) begin
        if (hdr_assoc_i) begin
          dl_a_r <= dial_level_i; // R1
          dg_a_r <= dial_gain_i; // R16
          svc_a_r <= svc_type_i; // R15
        end else begin
          dl_m_r <= dial_level_i; // R1
          dg_m_r <= dial_gain_i;
          if (blk_cnt_r != `ALGC_BLOCKS_PER_FRAME && blk_cnt_r != 3'h0)
            frame_err_r <= 1'b1; // R14
          // a word arriving with the header is block 0 of the new frame
          blk_cnt_r <= {2'b00, blk_valid_i && !blk_assoc_i}; // R14
        end
      end
      if (blk_valid_i) begin
        if (blk_assoc_i) begin
          rp_a_r <= rng_gain_i; // R3 R4
        end else begin
          rp_m_r <= rng_gain_i; // R3 R4
          if (!(hdr_valid_i && !hdr_assoc_i) && blk_cnt_r != 3'h7)
            blk_cnt_r <= blk_cnt_r + 3'h1; // R14
        end
      end
      if (f_valid && f_ready) begin
        mix_valid_o <= 1'b1;
        mix_assoc_o <= samp_assoc;
        mix_o <= sat; // R17
        last_gain_r <= tot_gain;
        if (samp_last) begin
          if (samp_assoc) rg_a_r <= rp_a_r; // R16
          else rg_m_r <= rp_m_r; // R16
        end
      end else if (mix_ready_i) begin
        mix_valid_o <= 1'b0;
      end
    end
  end

  // axi4-lite slave
  reg aw_got_r, w_got_r;
  reg [3:0] aw_r;
  reg [31:0] w_r;
  reg [3:0] ws_r;
  wire [3:0] wa = aw_got_r ? aw_r : s_axi_awaddr;
  wire [31:0] wd = w_got_r ? w_r : s_axi_wdata;
  wire [3:0] wsb = w_got_r ? ws_r : s_axi_wstrb;
  wire aw_ok = aw_got_r || (s_axi_awvalid && s_axi_awready);
  wire w_ok = w_got_r || (s_axi_wvalid && s_axi_wready);
  wire do_wr = aw_ok && w_ok && !s_axi_bvalid;

  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      ctrl_en_r <= 1'b1; // R6
      scale_r <= `ALGC_SCALE_RST; // R6
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      aw_r <= 4'h0;
      w_r <= 32'h0;
      ws_r <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= 2'b00;
      s_axi_rdata <= 32'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_r <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
        aw_got_r <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_r <= s_axi_wdata;
        ws_r <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
        w_got_r <= 1'b1;
      end
      if (do_wr) begin
        aw_got_r <= 1'b0;
        w_got_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= 2'b00;
        case (wa)
          `ALGC_REG_CTRL: begin
            if (wsb[0]) ctrl_en_r <= wd[0]; // R7
          end
          `ALGC_REG_SCALE: begin
            if (wsb[0]) scale_r[7:0] <= wd[7:0]; // R8
            if (wsb[1]) scale_r[15:8] <= wd[15:8]; // R8
          end
          `ALGC_REG_STATUS, `ALGC_REG_GAIN: begin
          end
          default: s_axi_bresp <= 2'b10;
        endcase
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= 2'b00;
        case (s_axi_araddr)
          `ALGC_REG_CTRL: s_axi_rdata <= {31'h0, ctrl_en_r};
          `ALGC_REG_SCALE: s_axi_rdata <= {16'h0, scale_r};
          `ALGC_REG_STATUS: s_axi_rdata <= {14'h0, frame_err_r, exc,
            svc_a_r, blk_cnt_r, dl_a_r, dl_m_r};
          `ALGC_REG_GAIN: s_axi_rdata <= {14'h0, last_gain_r};
          default: begin
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= 2'b10;
          end
        endcase
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

/* File: verification/algc_top_asserts.sv */
// Purpose: port checks for the level gain control block
// Assumes: one clock, reset_i async active high
// Notes: bound to algc_top below the module
`timescale 1ns/1ps
`default_nettype none
module algc_top_asserts (
  input wire logic clk_i, // clock
  input wire logic reset_i, // reset
  input wire logic smp_ready_o, // room
  input wire logic mix_valid_o, // out
  input wire logic mix_ready_i, // taken
  input wire logic [15:0] mix_o, // sample
  input wire logic s_axi_awvalid, // aw
  input wire logic s_axi_awready, // aw
  input wire logic s_axi_wvalid, // w
  input wire logic s_axi_wready, // w
  input wire logic s_axi_bvalid, // b
  input wire logic s_axi_bready, // b
  input wire logic [3:0] s_axi_araddr, // ar
  input wire logic s_axi_arvalid, // ar
  input wire logic s_axi_arready, // ar
  input wire logic s_axi_rvalid, // r
  input wire logic s_axi_rready, // r
  input wire logic [31:0] s_axi_rdata, // r
  input wire logic [1:0] s_axi_rresp // r
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  wr_resp_a: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |=> s_axi_bvalid)
    else $error("write response late");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  wr_block_a: assert property (s_axi_bvalid |-> !s_axi_awready &&
    !s_axi_wready) else $error("write taken while answering");
  rd_resp_a: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid) else $error("read data late");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
  rd_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answering");
  bad_addr_a: assert property (s_axi_arvalid && s_axi_arready &&
    s_axi_araddr[1:0] != 2'h0 |=> s_axi_rresp == 2'h2 &&
    s_axi_rdata == 32'h0) else $error("unmapped read not refused");
  mix_hold_a: assert property (mix_valid_o && !mix_ready_i |=>
    mix_valid_o && $stable(mix_o)) else $error("output sample dropped");
  cover property (s_axi_bvalid && s_axi_bready);
  cover property (!smp_ready_o);
  cover property (mix_valid_o && !mix_ready_i);
endmodule
bind algc_top algc_top_asserts u_chk (.clk_i, .reset_i, .smp_ready_o,
  .mix_valid_o, .mix_ready_i, .mix_o, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
  .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
  .s_axi_rready, .s_axi_rdata, .s_axi_rresp);
`default_nettype wire

/* File: verification/algc_parser_model.sv */
// Purpose: stream parser stand-in feeding fields and samples
// Assumes: driven after rising edges, samples held until taken
// Notes: released gain, service and sample buses show the inverse of their last value
`timescale 1ns/1ps
`default_nettype none
module algc_parser_model (
  input wire logic clk_i, // clock
  input wire logic smp_ready_i, // sample taken
  output logic fld_valid_o = 1'b0, // field pulse
  output logic blk_valid_o = 1'b0, // range word pulse
  output logic fld_assoc_o = 1'b0, // stream id
  output logic [4:0] dial_level_o = 5'h0, // level field
  output logic [17:0] dial_gain_o = 18'h0, // dialogue gain
  output logic [2:0] svc_type_o = 3'h0, // service type
  output logic [17:0] rng_gain_o = 18'h0, // range gain
  output logic smp_valid_o = 1'b0, // sample valid
  output logic smp_assoc_o = 1'b0, // sample stream
  output logic smp_last_o = 1'b0, // block end
  output logic [15:0] smp_o = 16'h0 // sample
);
  task automatic fields(input logic a, input logic [17:0] dg, rg,
    input logic [2:0] t);
    begin
      @(posedge clk_i);
      fld_valid_o <= 1'b1;
      blk_valid_o <= 1'b1;
      fld_assoc_o <= a;
      dial_level_o <= dg[14:10];
      dial_gain_o <= dg;
      rng_gain_o <= rg;
      svc_type_o <= t;
      @(posedge clk_i);
      fld_valid_o <= 1'b0;
      blk_valid_o <= 1'b0;
      dial_gain_o <= ~dg;
      rng_gain_o <= ~rg;
      svc_type_o <= ~t;
    end
  endtask
  // a range word alone, as for blocks 1 to 5 of a frame
  task automatic blk(input logic a, input logic [17:0] rg);
    begin
      @(posedge clk_i);
      blk_valid_o <= 1'b1;
      fld_assoc_o <= a;
      rng_gain_o <= rg;
      @(posedge clk_i);
      blk_valid_o <= 1'b0;
      rng_gain_o <= ~rg;
    end
  endtask
  task automatic smp(input logic a, l, input logic [15:0] v);
    begin
      @(posedge clk_i);
      smp_valid_o <= 1'b1;
      smp_assoc_o <= a;
      smp_last_o <= l;
      smp_o <= v;
      do @(posedge clk_i); while (!smp_ready_i);
      smp_valid_o <= 1'b0;
      smp_o <= ~v;
    end
  endtask
endmodule
`default_nettype wire

/* File: verification/tb_top.sv */
// Purpose: self-checking bench for the level gain control block
// Assumes: parser model drives fields and samples
// Notes: rows hold scale, range gain, sample and expected result
`timescale 1ns/1ps
`default_nettype none
`include "algc_defines.vh"
module tb_top;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic mix_ready_i = 1'b1;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
  logic [31:0] s_axi_wdata = 32'h0;
  wire fld_valid, fld_assoc, smp_valid_i, smp_assoc_i, smp_last_i;
  wire blk_valid;
  wire smp_ready_o, mix_valid_o, mix_assoc_o, s_axi_rvalid;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  wire [1:0] s_axi_rresp, s_axi_bresp;
  wire [2:0] svc_type_i;
  wire [4:0] dial_level_i;
  wire [17:0] dial_gain_i, rng_gain_i;
  wire [15:0] smp_i, mix_o;
  wire [31:0] s_axi_rdata;
  logic [15:0] q [$];
  logic [15:0] qa [$];
  logic [31:0] d;
  logic [1:0] r;
  logic [15:0] sc, s, e;
  logic [17:0] rg;
  int n_fail = 0, num_checks = 0, n_in = 0, b = 0;
  logic [65:0] rows [11] = '{
    {16'hFFFF, 18'h04000, 16'h03E8, 16'h03E8},
    {16'hFFFF, 18'h08000, 16'h03E8, 16'h07D0},
    {16'hFFFF, 18'h02000, 16'h03E8, 16'h01F4},
    {16'hFFFF, 18'h3F000, 16'h0040, 16'h03F0},
    {16'hFFFF, 18'h00410, 16'h4000, 16'h0410},
    {16'hFFFF, 18'h08000, 16'h7000, 16'h7FFF},
    {16'h0000, 18'h08000, 16'h03E8, 16'h03E8},
    {16'h00FF, 18'h08000, 16'h03E8, 16'h03E8},
    {16'h00FF, 18'h02000, 16'h03E8, 16'h01F4},
    {16'hFF00, 18'h08000, 16'h03E8, 16'h07D0},
    {16'hFF00, 18'h02000, 16'h03E8, 16'h03E8}};
  logic [2:0] svc [4] = '{3'h3, `ALGC_SVC_NARR, `ALGC_SVC_COMM,
    `ALGC_SVC_VOICE};
  always #4 clk_i = ~clk_i;
  algc_top uut (.clk_i, .reset_i, .hdr_valid_i(fld_valid),
    .hdr_assoc_i(fld_assoc), .dial_level_i, .dial_gain_i, .svc_type_i,
    .blk_valid_i(blk_valid), .blk_assoc_i(fld_assoc), .rng_gain_i,
    .smp_valid_i, .smp_ready_o, .smp_assoc_i, .smp_last_i, .smp_i,
    .mix_valid_o, .mix_ready_i, .mix_assoc_o, .mix_o, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  algc_parser_model pm (.clk_i, .smp_ready_i(smp_ready_o),
    .fld_valid_o(fld_valid), .fld_assoc_o(fld_assoc),
    .blk_valid_o(blk_valid),
    .dial_level_o(dial_level_i), .dial_gain_o(dial_gain_i),
    .svc_type_o(svc_type_i), .rng_gain_o(rng_gain_i),
    .smp_valid_o(smp_valid_i), .smp_assoc_o(smp_assoc_i),
    .smp_last_o(smp_last_i), .smp_o(smp_i));
  always @(posedge clk_i) begin
    if (mix_valid_o && mix_ready_i && !mix_assoc_o) q.push_back(mix_o);
    if (mix_valid_o && mix_ready_i && mix_assoc_o) qa.push_back(mix_o);
    if (smp_valid_i && smp_ready_o) n_in++;
  end
  task automatic chk_smp(input logic [15:0] g, ex);
    num_checks++;
    if (g !== ex) begin
      n_fail++;
      $display("ERROR %0t sample %h expected %h", $time, g, ex);
    end
  endtask
  task automatic chk_reg(input logic [31:0] g, ex);
    num_checks++;
    if (g !== ex) begin
      n_fail++;
      $display("ERROR %0t value %h expected %h", $time, g, ex);
    end
  endtask
  task give_verdict;
    if (n_fail == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk_i);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk_i);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge clk_i);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk_i);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  // the first sample closes the old block so the new word takes effect
  task automatic run(input logic [17:0] dg, g, input logic [15:0] v, ex);
    q.delete();
    pm.fields(1'b0, dg, g, 3'h0);
    pm.smp(1'b0, 1'b1, 16'h0001);
    pm.smp(1'b0, 1'b1, v);
    for (int k = 0; k < 200 && q.size() < 2; k++) @(posedge clk_i);
    chk_smp(q[1], ex);
  endtask
  initial begin
    repeat (3) @(posedge clk_i);
    reset_i <= 1'b0;
    rd(`ALGC_REG_CTRL);
    chk_reg({31'h0, d[0]}, 32'h1);
    rd(`ALGC_REG_SCALE);
    chk_reg({16'h0, d[15:0]}, 32'hFFFF);
    for (int i = 0; i < 11; i++) begin
      {sc, rg, s, e} = rows[i];
      wr(`ALGC_REG_SCALE, {16'h0, sc});
      run(18'h04000, rg, s, e);
    end
    wr(`ALGC_REG_SCALE, 32'hFFFF);
    run(18'h08000, 18'h04000, 16'h03E8, 16'h07D0);
    rd(`ALGC_REG_GAIN);
    chk_reg(d, 32'h00008000);
    wr(`ALGC_REG_CTRL, 32'h0);
    run(18'h04000, 18'h08000, 16'h03E8, 16'h03E8);
    wr(`ALGC_REG_CTRL, 32'h1);
    rd(4'h2);
    chk_reg({d[29:0], r}, 32'h2);
    wr(4'h2, 32'h0);
    chk_reg({30'h0, r}, 32'h2);
    for (int i = 0; i < 4; i++) begin
      pm.fields(1'b1, 18'h08000, 18'h08000, svc[i]);
      pm.smp(1'b1, 1'b1, 16'h0001);
      run(18'h04000, 18'h04000, 16'h03E8, i ? 16'h07D0 : 16'h03E8);
    end
    // associated sample: its own dialogue gain x2 and range gain x2
    qa.delete();
    pm.smp(1'b1, 1'b0, 16'h03E8);
    for (int k = 0; k < 200 && qa.size() < 1; k++) @(posedge clk_i);
    chk_smp(qa[0], 16'h0FA0);
    mix_ready_i <= 1'b0;
    q.delete();
    b = n_in;
    fork
      repeat (40) pm.smp(1'b0, 1'b0, 16'h0010);
    join_none
    repeat (150) @(posedge clk_i);
    chk_reg({31'h0, smp_ready_o}, 32'h0);
    chk_reg({31'h0, n_in - b >= 32}, 32'h1);
    mix_ready_i <= 1'b1;
    for (int k = 0; k < 500 && q.size() < 40; k++) @(posedge clk_i);
    chk_reg(q.size(), 32'h28);
    // mid-run reset, then one whole frame and one short frame
    wr(`ALGC_REG_SCALE, 32'h1234);
    reset_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    reset_i <= 1'b0;
    rd(`ALGC_REG_SCALE);
    chk_reg(d, {16'h0, `ALGC_SCALE_RST});
    pm.fields(1'b0, 18'h04000, 18'h04000, 3'h0);
    repeat (5) pm.blk(1'b0, 18'h04000);
    pm.fields(1'b0, 18'h04000, 18'h04000, 3'h0);
    rd(`ALGC_REG_STATUS);
    chk_reg(d, 32'h00000410);
    repeat (2) pm.blk(1'b0, 18'h04000);
    pm.fields(1'b0, 18'h04000, 18'h04000, 3'h0);
    rd(`ALGC_REG_STATUS);
    chk_reg(d, 32'h00020410);
    give_verdict;
  end
  initial begin
    #200000;
    n_fail++;
    give_verdict;
  end
endmodule
`default_nettype wire
